//--- hdl/csr_core.sv
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "csr_defs.svh"
module csr_core #(
   parameter int unsigned PC_W = 18,
   parameter int unsigned SP_W = 5,
   parameter int unsigned ACC_W = 16
) (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire logic reset_in_low_pin_in,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // pins
   input wire logic probe_attached_in,
   input wire logic [5:0] gp_pin_in,
   output logic [5:0] gp_pin_out,
   output logic [5:0] gp_pin_oe_n_out,
   input wire logic [1:0] debug_shared_port_in,
   output logic [1:0] debug_shared_port_out,
   output logic [1:0] debug_shared_port_oe_n_out,
   output logic probe_clock_pin_out,
   input wire logic probe_data_pin_in,
   output logic audio_out_pos_out,
   output logic audio_out_neg_out,
   // status
   output logic [PC_W-1:0] pc_out,
   output logic pm_busy_out
);
   if (PC_W != 18 || SP_W != 5 || ACC_W != 16) begin : g_width_check
      $error("csr_core: widths fixed by the core");
   end

   // ----------------------------------------
   // reset pin synchroniser
   // ----------------------------------------
   // pin resets asynchronously, release is synchronised
   logic rst_pin_meta;
   logic rst_pin_sync;
   wire logic rst_all = rst_in | ~reset_in_low_pin_in;
   always_ff @(posedge clk_in or posedge rst_all) begin
      if (rst_all) begin
         rst_pin_meta <= 1'b0;
         rst_pin_sync <= 1'b0;
      end else begin
         rst_pin_meta <= 1'b1;
         rst_pin_sync <= rst_pin_meta;
      end
   end
   wire logic rst = rst_in | ~rst_pin_sync;

   // both shared pins and the probe data pin, each through its own two flops
   logic [2:0] dbg_meta;
   logic [2:0] dbg_sync;
   logic probe_meta;
   logic probe_sync;
   logic [5:0] gp_meta;
   logic [5:0] gp_sync;
   always_ff @(posedge clk_in or posedge rst) begin
      if (rst) begin
         dbg_meta <= 3'h0;
         dbg_sync <= 3'h0;
         probe_meta <= 1'b0;
         probe_sync <= 1'b0;
         gp_meta <= 6'h00;
         gp_sync <= 6'h00;
      end else begin
         dbg_meta <= {debug_shared_port_in, probe_data_pin_in};
         dbg_sync <= dbg_meta;
         probe_meta <= probe_attached_in;
         probe_sync <= probe_meta;
         gp_meta <= gp_pin_in;
         gp_sync <= gp_meta;
      end
   end

   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic [15:0] accumulator_reg;
   logic [1:0] flags;
   logic [4:0] call_stack_pointer;
   logic [1:0] code_bank_select;
   logic [15:0] jump_high_part;
   logic [17:0] pc;
   logic [15:0] index_zero_reg;
   logic [15:0] pointer_zero_reg;
   logic [15:0] ring_length_reg;
   logic [3:0] pm_wait;
   logic [3:0] pm_count;
   csr_pkg::csr_port_s port_cfg;
   wire logic [7:0] index_ring_length = ring_length_reg[`CSR_RING_IDX_LSB +: 8];
   wire logic [7:0] pointer_ring_length = ring_length_reg[`CSR_RING_PTR_LSB +: 8];

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   // readies drop while frozen, so no handshake is seen that the flops miss
   assign s_axi_awready_out = clk_en_in & ~aw_held & ~s_axi_bvalid_out;
   assign s_axi_wready_out = clk_en_in & ~w_held & ~s_axi_bvalid_out;
   assign s_axi_arready_out = clk_en_in & ~s_axi_rvalid_out;
   wire logic wr_go = aw_held & w_held & ~s_axi_bvalid_out;
   wire logic wr_full = w_strb[0] & w_strb[1];
   wire logic [15:0] wd = w_data[15:0];

   always_ff @(posedge clk_in or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `CSR_RESP_OKAY;
      end else if (clk_en_in) begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (aw_addr > `CSR_ADDR_WAIT || aw_addr[1:0] != 2'h0) ?
               `CSR_RESP_SLVERR : `CSR_RESP_OKAY;
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // instruction strobes and stall
   // ----------------------------------------
   // op register write: [2:0] op, bit 8 pm access; a pm access stalls
   // for pm_wait cycles, other ops retire in the write cycle, or are dropped while a stall runs
   wire logic op_wr = wr_go && aw_addr == `CSR_ADDR_OP && w_strb[0];
   csr_pkg::csr_op_e op;
   assign op = op_wr ? csr_pkg::csr_op_e'(w_data[2:0]) : csr_pkg::CSR_OP_NONE;
   wire logic op_pm = op_wr & w_data[8];
   assign pm_busy_out = pm_count != 4'h0;

   always_ff @(posedge clk_in or posedge rst) begin
      if (rst) begin
         pm_count <= 4'h0;
      end else if (clk_en_in) begin
         if (op_pm && !pm_busy_out) begin
            pm_count <= pm_wait;
         end else if (pm_busy_out) begin
            pm_count <= pm_count - 4'h1;
         end
      end
   end
   wire logic op_ok = op_wr & ~pm_busy_out;

   // ----------------------------------------
   // accumulator and flags
   // ----------------------------------------
   // ALU result arrives as a write with strobe bytes 0 and 1 high
   always_ff @(posedge clk_in or posedge rst) begin
      if (rst) begin
         accumulator_reg <= 16'h0000;
         flags <= 2'h0;
      end else if (clk_en_in && wr_go && aw_addr == `CSR_ADDR_ACC && wr_full) begin
         accumulator_reg <= wd;
         flags[`CSR_FLAG_Z] <= wd == 16'h0000;
         flags[`CSR_FLAG_N] <= wd[15];
      end
   end

   // ----------------------------------------
   // stack, bank, program counter
   // ----------------------------------------
   wire logic [17:0] long_target = {code_bank_select, jump_high_part};
   wire logic bank_ok = wd[1:0] == `CSR_BANK_FLASH || wd[1:0] == `CSR_BANK_SRAM;
   always_ff @(posedge clk_in or posedge rst) begin
      if (rst) begin
         call_stack_pointer <= 5'h00;
         code_bank_select <= `CSR_BANK_FLASH;
         jump_high_part <= 16'h0000;
         pc <= 18'h00000;
         pm_wait <= `CSR_PM_WAIT_RST;
      end else if (clk_en_in) begin
         if (wr_go && wr_full) begin
            if (aw_addr == `CSR_ADDR_BANK && bank_ok) begin
               code_bank_select <= wd[1:0];
            end else if (aw_addr == `CSR_ADDR_JHIGH) begin
               jump_high_part <= wd;
            end else if (aw_addr == `CSR_ADDR_WAIT) begin
               pm_wait <= wd[3:0];
            end
         end
         if (op_ok) begin
            case (op)
               csr_pkg::CSR_OP_CALL: begin
                  call_stack_pointer <= call_stack_pointer + 5'h01;
                  pc <= pc + 18'h00001;
               end
               csr_pkg::CSR_OP_RET: begin
                  call_stack_pointer <= call_stack_pointer - 5'h01;
                  pc <= pc + 18'h00001;
               end
               csr_pkg::CSR_OP_LONG_JUMP_OP: pc <= long_target;
               csr_pkg::CSR_OP_LONG_CALL_OP: begin
                  pc <= long_target;
                  call_stack_pointer <= call_stack_pointer + 5'h01;
               end
               csr_pkg::CSR_OP_STEP: pc <= pc + 18'h00001;
               default: pc <= pc;
            endcase
         end
      end
   end
   assign pc_out = pc;

   // ----------------------------------------
   // ring addressing
   // ----------------------------------------
   // ring length 0 means linear addressing; stride is 1 on step op
   function automatic logic [15:0] ring_step(input logic [15:0] cur, input logic [7:0] len);
      logic [15:0] base;
      logic [15:0] nxt;
      base = cur & ~16'h00FF;
      nxt = cur + 16'h0001;
      if (len != 8'h00 && nxt[7:0] >= len) begin
         ring_step = base;
      end else begin
         ring_step = nxt;
      end
   endfunction

   always_ff @(posedge clk_in or posedge rst) begin
      if (rst) begin
         index_zero_reg <= 16'h0000;
         pointer_zero_reg <= 16'h0000;
         ring_length_reg <= 16'h0000;
      end else if (clk_en_in) begin
         if (wr_go && wr_full && aw_addr == `CSR_ADDR_IDX) begin
            index_zero_reg <= wd;
         end else if (op_ok && op == csr_pkg::CSR_OP_STEP && w_data[16]) begin
            index_zero_reg <= ring_step(index_zero_reg, index_ring_length);
         end
         if (wr_go && wr_full && aw_addr == `CSR_ADDR_PTR) begin
            pointer_zero_reg <= wd;
         end else if (op_ok && op == csr_pkg::CSR_OP_STEP && w_data[17]) begin
            pointer_zero_reg <= ring_step(pointer_zero_reg, pointer_ring_length);
         end
         if (wr_go && wr_full && aw_addr == `CSR_ADDR_RING) begin
            ring_length_reg <= wd;
         end
      end
   end

   // ----------------------------------------
   // pins
   // ----------------------------------------
   always_ff @(posedge clk_in or posedge rst) begin
      if (rst) begin
         port_cfg <= '0;
      end else if (clk_en_in && wr_go && wr_full && aw_addr == `CSR_ADDR_PORT) begin
         port_cfg <= wd;
      end
   end
   assign gp_pin_out = port_cfg.gp_out & port_cfg.gp_dir;
   assign gp_pin_oe_n_out = ~port_cfg.gp_dir;
   // probe owns both shared pins; data pin direction is left to the probe
   assign probe_clock_pin_out = probe_sync & dbg_sync[2];
   assign debug_shared_port_out = probe_sync ? 2'h0 : port_cfg.dbg_out & port_cfg.dbg_dir;
   assign debug_shared_port_oe_n_out = probe_sync ? 2'h3 : ~port_cfg.dbg_dir;
   // no pwm engine here; outputs parked low
   assign audio_out_pos_out = 1'b0;
   assign audio_out_neg_out = 1'b0;

   // ----------------------------------------
   // read path
   // ----------------------------------------
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr_in == `CSR_ADDR_ACC) begin
         next_rdata[15:0] = accumulator_reg;
      end else if (s_axi_araddr_in == `CSR_ADDR_FLAGS) begin
         next_rdata[1:0] = flags;
      end else if (s_axi_araddr_in == `CSR_ADDR_STACK) begin
         next_rdata[4:0] = call_stack_pointer;
      end else if (s_axi_araddr_in == `CSR_ADDR_BANK) begin
         next_rdata[1:0] = code_bank_select;
      end else if (s_axi_araddr_in == `CSR_ADDR_JHIGH) begin
         next_rdata[15:0] = jump_high_part;
      end else if (s_axi_araddr_in == `CSR_ADDR_PC) begin
         next_rdata[17:0] = pc;
      end else if (s_axi_araddr_in == `CSR_ADDR_IDX) begin
         next_rdata[15:0] = index_zero_reg;
      end else if (s_axi_araddr_in == `CSR_ADDR_PTR) begin
         next_rdata[15:0] = pointer_zero_reg;
      end else if (s_axi_araddr_in == `CSR_ADDR_RING) begin
         next_rdata[15:0] = ring_length_reg;
      end else if (s_axi_araddr_in == `CSR_ADDR_OP) begin
         next_rdata[0] = pm_busy_out;
      end else if (s_axi_araddr_in == `CSR_ADDR_PORT) begin
         next_rdata[15:0] = {gp_sync, probe_sync ? {dbg_sync[2], dbg_sync[0]} : dbg_sync[2:1],
            port_cfg.gp_dir, port_cfg.dbg_dir};
      end else if (s_axi_araddr_in == `CSR_ADDR_WAIT) begin
         next_rdata[3:0] = pm_wait;
      end
   end
   wire logic rd_bad = s_axi_araddr_in > `CSR_ADDR_WAIT || s_axi_araddr_in[1:0] != 2'h0;

   always_ff @(posedge clk_in or posedge rst) begin
      if (rst) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `CSR_RESP_OKAY;
      end else if (clk_en_in) begin
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= next_rdata;
            s_axi_rresp_out <= rd_bad ? `CSR_RESP_SLVERR : `CSR_RESP_OKAY;
         end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_acc_flag_zero: assert property (@(posedge clk_in) disable iff (rst)
      $changed(accumulator_reg) |-> flags[`CSR_FLAG_Z] == (accumulator_reg == 16'h0000))
      else $error("zero flag does not follow accumulator");
   a_stack_call_up: assert property (@(posedge clk_in) disable iff (rst)
      clk_en_in && op_ok && op == csr_pkg::CSR_OP_CALL |=>
      call_stack_pointer == $past(call_stack_pointer) + 5'h01)
      else $error("stack pointer did not rise on call");
   a_stack_ret_down: assert property (@(posedge clk_in) disable iff (rst)
      clk_en_in && op_ok && op == csr_pkg::CSR_OP_RET |=>
      call_stack_pointer == $past(call_stack_pointer) - 5'h01)
      else $error("stack pointer did not fall on return");
   a_bank_legal: assert property (@(posedge clk_in) disable iff (rst)
      code_bank_select == `CSR_BANK_FLASH || code_bank_select == `CSR_BANK_SRAM)
      else $error("reserved bank selected");
   a_long_jump: assert property (@(posedge clk_in) disable iff (rst)
      clk_en_in && op_ok && op == csr_pkg::CSR_OP_LONG_JUMP_OP |=>
      pc == {$past(code_bank_select), $past(jump_high_part)})
      else $error("long jump target wrong");
   a_idx_ring_wrap: assert property (@(posedge clk_in) disable iff (rst)
      index_ring_length != 8'h00 && $changed(index_zero_reg) &&
      !$past(wr_go) |-> index_zero_reg[7:0] < index_ring_length)
      else $error("index left its ring");
   a_pm_stall: assert property (@(posedge clk_in) disable iff (rst)
      clk_en_in && op_pm && !pm_busy_out && pm_wait >= 4'h2 |=> pm_busy_out ##1 pm_busy_out)
      else $error("pm access did not stall");
   a_ports_low: assert property (@(posedge clk_in)
      $fell(rst) |-> gp_pin_out == 6'h00 && gp_pin_oe_n_out == 6'h3F && !audio_out_pos_out)
      else $error("pins not low after reset");
endmodule // csr_core

//--- hdl/csr_defs.svh
`ifndef CSR_DEFS_SVH
`define CSR_DEFS_SVH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define CSR_ADDR_ACC 8'h00
`define CSR_ADDR_FLAGS 8'h04
`define CSR_ADDR_STACK 8'h08
`define CSR_ADDR_BANK 8'h0C
`define CSR_ADDR_JHIGH 8'h10
`define CSR_ADDR_PC 8'h14
`define CSR_ADDR_IDX 8'h18
`define CSR_ADDR_PTR 8'h1C
`define CSR_ADDR_RING 8'h20
`define CSR_ADDR_OP 8'h24
`define CSR_ADDR_PORT 8'h28
`define CSR_ADDR_WAIT 8'h2C
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define CSR_RING_IDX_LSB 0
`define CSR_RING_PTR_LSB 8
`define CSR_FLAG_Z 0
`define CSR_FLAG_N 1
`define CSR_BANK_FLASH 2'h0
`define CSR_BANK_SRAM 2'h2
`define CSR_PM_WAIT_RST 4'h2
`define CSR_RESP_OKAY 2'h0
`define CSR_RESP_SLVERR 2'h2
`endif

//--- hdl/csr_pkg.sv
package csr_pkg;
   typedef enum logic [2:0] {
      CSR_OP_NONE,
      CSR_OP_CALL,
      CSR_OP_RET,
      CSR_OP_LONG_JUMP_OP,
      CSR_OP_LONG_CALL_OP,
      CSR_OP_STEP
   } csr_op_e;
   typedef struct packed {
      logic [5:0] gp_dir;
      logic [5:0] gp_out;
      logic [1:0] dbg_dir;
      logic [1:0] dbg_out;
   } csr_port_s;
endpackage

//--- verification/csr_core_bench.sv
`timescale 1ns/1ps
`include "csr_defs.svh"
module csr_core_bench;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic clk_in, rst_in, clk_en_in, reset_in_low_pin_in;
   logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
   logic [3:0] s_axi_wstrb_in;
   logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   logic s_axi_rvalid_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
   logic probe_attached_in, probe_data_pin_in, probe_clock_pin_out;
   logic [5:0] gp_pin_in, gp_pin_out, gp_pin_oe_n_out;
   logic [1:0] debug_shared_port_in, debug_shared_port_out, debug_shared_port_oe_n_out;
   logic audio_out_pos_out, audio_out_neg_out, pm_busy_out;
   logic [17:0] pc_out;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   csr_core DUT (.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
      .reset_in_low_pin_in(reset_in_low_pin_in), .s_axi_awaddr_in(s_axi_awaddr_in),
      .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
      .s_axi_wdata_in(s_axi_wdata_in), .s_axi_wstrb_in(s_axi_wstrb_in),
      .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
      .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
      .s_axi_bready_in(s_axi_bready_in), .s_axi_araddr_in(s_axi_araddr_in),
      .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
      .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
      .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
      .probe_attached_in(probe_attached_in), .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out),
      .gp_pin_oe_n_out(gp_pin_oe_n_out), .debug_shared_port_in(debug_shared_port_in),
      .debug_shared_port_out(debug_shared_port_out),
      .debug_shared_port_oe_n_out(debug_shared_port_oe_n_out),
      .probe_clock_pin_out(probe_clock_pin_out), .probe_data_pin_in(probe_data_pin_in),
      .audio_out_pos_out(audio_out_pos_out), .audio_out_neg_out(audio_out_neg_out),
      .pc_out(pc_out), .pm_busy_out(pm_busy_out));
   // ----------------------------------------
   // clock, hang guard, verdict
   // ----------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic report_and_stop();
      if (err_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // the whole run needs well under 2000 cycles; this ceiling only cuts a hang
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // ----------------------------------------
   // bus master: handshakes sampled at the falling edge, so the view is the
   // one the rising edge will see, free of races with the slave's own flops
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ha, hw, aw_done, w_done, got;
      @(posedge clk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      while (!(aw_done && w_done)) begin
         @(negedge clk_in);
         ha = s_axi_awvalid_in && s_axi_awready_out;
         hw = s_axi_wvalid_in && s_axi_wready_out;
         @(posedge clk_in);
         if (ha) begin
            s_axi_awvalid_in <= 1'b0;
            aw_done = 1'b1;
         end
         if (hw) begin
            s_axi_wvalid_in <= 1'b0;
            w_done = 1'b1;
         end
      end
      s_axi_bready_in <= 1'b1;
      do begin
         @(negedge clk_in);
         got = s_axi_bvalid_out;
         r = s_axi_bresp_out;
         @(posedge clk_in);
      end while (got !== 1'b1);
      s_axi_bready_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ha, got;
      @(posedge clk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      do begin
         @(negedge clk_in);
         ha = s_axi_arready_out;
         @(posedge clk_in);
      end while (ha !== 1'b1);
      s_axi_arvalid_in <= 1'b0;
      s_axi_rready_in <= 1'b1;
      do begin
         @(negedge clk_in);
         got = s_axi_rvalid_out;
         d = s_axi_rdata_out;
         r = s_axi_rresp_out;
         @(posedge clk_in);
      end while (got !== 1'b1);
      s_axi_rready_in <= 1'b0;
   endtask
   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      check("write response", {30'h0, r}, {30'h0, `CSR_RESP_OKAY});
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      check("read response", {30'h0, r}, {30'h0, `CSR_RESP_OKAY});
      check(what, d, exp);
   endtask
   task automatic op(input logic [31:0] v);
      wr_ok(`CSR_ADDR_OP, v);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_state();
      check("gp out", {26'h0, gp_pin_out}, 32'h0);
      check("gp oe_n", {26'h0, gp_pin_oe_n_out}, 32'h3F);
      check("audio", {30'h0, audio_out_pos_out, audio_out_neg_out}, 32'h0);
      check("pc pin", {14'h0, pc_out}, 32'h0);
      rd_chk(`CSR_ADDR_STACK, 32'h0, "stack");
      rd_chk(`CSR_ADDR_WAIT, {28'h0, `CSR_PM_WAIT_RST}, "pm wait");
      rd_chk(`CSR_ADDR_BANK, {30'h0, `CSR_BANK_FLASH}, "bank");
   endtask
   task automatic t_accumulator();
      wr_ok(`CSR_ADDR_ACC, 32'h0000_0000);
      rd_chk(`CSR_ADDR_FLAGS, 32'h1 << `CSR_FLAG_Z, "flags zero");
      wr_ok(`CSR_ADDR_ACC, 32'hFFFF_8001);
      rd_chk(`CSR_ADDR_ACC, 32'h0000_8001, "acc 16 bit");
      rd_chk(`CSR_ADDR_FLAGS, 32'h1 << `CSR_FLAG_N, "flags neg");
   endtask
   task automatic t_stack();
      for (int i = 1; i <= 32; i++) begin
         op(32'(csr_pkg::CSR_OP_CALL));
         if (i == 31 || i == 32) rd_chk(`CSR_ADDR_STACK, 32'(i % 32), "stack up");
      end
      op(32'(csr_pkg::CSR_OP_RET));
      rd_chk(`CSR_ADDR_STACK, 32'h1F, "stack down wrap");
      wr_ok(`CSR_ADDR_STACK, 32'h5);
      rd_chk(`CSR_ADDR_STACK, 32'h1F, "stack read only");
   endtask
   task automatic t_long_jump();
      wr_ok(`CSR_ADDR_BANK, {30'h0, `CSR_BANK_SRAM});
      wr_ok(`CSR_ADDR_BANK, 32'h1);
      wr_ok(`CSR_ADDR_BANK, 32'h3);
      rd_chk(`CSR_ADDR_BANK, {30'h0, `CSR_BANK_SRAM}, "reserved bank");
      wr_ok(`CSR_ADDR_JHIGH, 32'hFFFF);
      op(32'(csr_pkg::CSR_OP_LONG_JUMP_OP));
      check("pc long_jump_op", {14'h0, pc_out}, 32'h2FFFF);
      rd_chk(`CSR_ADDR_PC, 32'h2FFFF, "pc reg");
      wr_ok(`CSR_ADDR_BANK, {30'h0, `CSR_BANK_FLASH});
      wr_ok(`CSR_ADDR_JHIGH, 32'h1234);
      op(32'(csr_pkg::CSR_OP_LONG_CALL_OP));
      check("pc long_call_op", {14'h0, pc_out}, 32'h01234);
      rd_chk(`CSR_ADDR_STACK, 32'h0, "stack long_call_op");
   endtask
   task automatic t_ring();
      wr_ok(`CSR_ADDR_RING, 32'h0000_0304);
      wr_ok(`CSR_ADDR_IDX, 32'h1200);
      wr_ok(`CSR_ADDR_PTR, 32'h5600);
      for (int i = 1; i <= 4; i++) begin
         op(32'h0001_0000 | 32'(csr_pkg::CSR_OP_STEP));
         rd_chk(`CSR_ADDR_IDX, 32'h1200 + 32'(i % 4), "index ring");
      end
      for (int i = 1; i <= 3; i++) begin
         op(32'h0002_0000 | 32'(csr_pkg::CSR_OP_STEP));
         rd_chk(`CSR_ADDR_PTR, 32'h5600 + 32'(i % 3), "pointer ring");
      end
      rd_chk(`CSR_ADDR_IDX, 32'h1200, "index held");
   endtask
   task automatic t_pm_stall();
      logic [17:0] pc0;
      int n;
      pc0 = pc_out;
      op(32'(csr_pkg::CSR_OP_STEP));
      check("single cycle step", {14'h0, pc_out}, {14'h0, pc0 + 18'h1});
      check("no stall", {31'h0, pm_busy_out}, 32'h0);
      wr_ok(`CSR_ADDR_WAIT, 32'hC);
      op(32'h0000_0100);
      check("pm busy", {31'h0, pm_busy_out}, 32'h1);
      op(32'(csr_pkg::CSR_OP_STEP));
      check("op while busy", {14'h0, pc_out}, {14'h0, pc0 + 18'h1});
      clk_en_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      check("frozen stall", {31'h0, pm_busy_out}, 32'h1);
      clk_en_in <= 1'b1;
      n = 0;
      while (pm_busy_out !== 1'b0 && n < 14) begin
         @(posedge clk_in);
         n++;
      end
      check("stall ends", {31'h0, pm_busy_out}, 32'h0);
      op(32'(csr_pkg::CSR_OP_STEP));
      check("step after stall", {14'h0, pc_out}, {14'h0, pc0 + 18'h2});
   endtask
   task automatic t_ports();
      gp_pin_in <= 6'h2A;
      debug_shared_port_in <= 2'b11;
      wr_ok(`CSR_ADDR_PORT, 32'hFD5D);
      check("gp drive", {20'h0, gp_pin_out, gp_pin_oe_n_out}, 32'h540);
      check("dbg drive", {28'h0, debug_shared_port_out, debug_shared_port_oe_n_out}, 32'h4);
      rd_chk(`CSR_ADDR_PORT, 32'hABFF, "port readback");
      probe_attached_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      check("probe oe_n", {30'h0, debug_shared_port_oe_n_out}, 32'h3);
      check("probe clock", {31'h0, probe_clock_pin_out}, 32'h1);
      debug_shared_port_in <= 2'b01;
      probe_data_pin_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      check("probe clock low", {31'h0, probe_clock_pin_out}, 32'h0);
      probe_attached_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      check("port again", {30'h0, debug_shared_port_oe_n_out}, 32'h0);
   endtask
   task automatic t_bus_errors();
      logic [31:0] d;
      logic [1:0] r;
      rd(8'h02, d, r);
      check("unaligned resp", {29'h0, r, d[0]}, {29'h0, `CSR_RESP_SLVERR, 1'b0});
      rd(8'h30, d, r);
      check("unmapped read", d, 32'h0);
      wr(8'h30, 32'h1, r);
      check("unmapped write", {30'h0, r}, {30'h0, `CSR_RESP_SLVERR});
   endtask
   task automatic t_reset_pin();
      wr_ok(`CSR_ADDR_ACC, 32'h1234);
      @(posedge clk_in);
      reset_in_low_pin_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      check("pin reset pc", {14'h0, pc_out}, 32'h0);
      check("pin reset gp", {26'h0, gp_pin_oe_n_out}, 32'h3F);
      reset_in_low_pin_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rd_chk(`CSR_ADDR_ACC, 32'h0, "pin reset acc");
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_in = 1'b1;
      // clock enable starts high; only t_pm_stall drops it, for 20 edges
      clk_en_in = 1'b1;
      reset_in_low_pin_in = 1'b1;
      s_axi_awaddr_in = 8'h00;
      s_axi_araddr_in = 8'h00;
      s_axi_wdata_in = 32'h0;
      s_axi_wstrb_in = 4'hF;
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
      {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
      probe_attached_in = 1'b0;
      probe_data_pin_in = 1'b0;
      gp_pin_in = 6'h00;
      debug_shared_port_in = 2'h0;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      // the reset synchroniser holds the block two more edges
      repeat (2) @(posedge clk_in);
      t_reset_state();
      t_accumulator();
      t_stack();
      t_long_jump();
      t_ring();
      t_pm_stall();
      t_ports();
      t_bus_errors();
      t_reset_pin();
      report_and_stop();
   end
endmodule // csr_core_bench
